// ==== lid_pkg.sv ====
package lid_pkg;

  // channel counts
  localparam int SG_CH = 14;
  localparam int SP_CH = 8;

  // register addresses as carried in frame bits 31..25
  localparam logic [6:0]  ADDR_GND_CMP_ONLY = 7'h13;
  localparam logic [6:0]  ADDR_PROG_THR     = 7'h14;
  localparam logic [6:0]  ADDR_GND_THR      = 7'h15;
  localparam logic [6:0]  ADDR_PROG_POLL    = 7'h16;

  // writable field masks and power-on values
  localparam logic [23:0] MASK_SG   = 24'h003FFF;
  localparam logic [23:0] MASK_SP   = 24'h0000FF;
  localparam logic [23:0] RST_REG   = 24'h000000;
  localparam logic [6:0]  RST_ADDR  = 7'h00;

  // frame layout
  localparam logic [5:0]  FRAME_BITS = 6'h20;
  localparam logic [5:0]  CNT_SAT    = 6'h3F;
  localparam logic [7:0]  REPLY_PAD  = 8'h00;

  // low-power sampling clock
  localparam int          CLK_PERIOD_NS  = 40;
  localparam int          LPM_PERIOD_NS  = 1000;
  localparam int          LPM_TICK_CYC   = (LPM_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0]  LPM_TICK_LAST  = 8'(LPM_TICK_CYC - 1);

  // one spi frame, msb first
  typedef struct packed {
    logic [6:0]  addr;
    logic        wr;
    logic [23:0] data;
  } lid_frame_t;

  // reply word
  typedef struct packed {
    logic [7:0]  pad;
    logic        fault;
    logic        intFlag;
    logic [21:0] regData;
  } lid_reply_t;

  typedef enum logic [1:0] {THR_DELTA, THR_NORMAL, THR_FIXED_4V0} lid_thr_t;
  typedef enum logic [1:0] {POLL_BATT_2MA2, POLL_GND_1MA0, POLL_WETTING, POLL_OFF} lid_poll_t;
  typedef enum logic {SPI_IDLE, SPI_SHIFT} lid_spi_state_t;

  // per-channel low-power controls handed to the analog front end
  typedef struct packed {
    lid_thr_t  [SG_CH-1:0] sgThr;
    lid_thr_t  [SP_CH-1:0] spThr;
    lid_poll_t [SG_CH-1:0] sgPoll;
    lid_poll_t [SP_CH-1:0] spPoll;
    logic      [SG_CH-1:0] sgCompEn;
  } lid_chan_ctl_t;

endpackage : lid_pkg

// ==== lid_sync.sv ====
`timescale 1ns/100ps
module lid_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rstn,
  // asynchronous levels in, synchronised levels out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta;

  // two stages; the first is read by the second only
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule : lid_sync

// ==== lid_top.sv ====
`timescale 1ns/100ps
// How it works
// R1: comparator-only ground channel: comparator on, no current
// R2: sample each low-power tick, any change wakes
// R3: comparator-only meant for driven 5 V inputs
// R4: programmable ground channel: 0 delta, 1 normal
// R5: programmable battery channel always fixed 4.0 V threshold
// R6: ground channel threshold bit: 0 delta, 1 normal
// R7: host sets current high enough for normal threshold
// R8: poll bit 0: 2.2 mA battery, 1.0 mA ground
// R9: poll bit 1: use programmed wetting current
// R10: frame: address 31..25, write 24, data 23..0
// R11: reply: fault 23, interrupt 22, data 21..0
// R12: no wake enabled: polling timer stopped
// R13: unused data bits ignored, always read zero
module lid_top
  import lid_pkg::*;
(
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rstn,
  // spi pins
  input  wire logic                 sclk,
  input  wire logic                 csN,
  input  wire logic                 mosi,
  output logic                      miso,
  output logic                      misoEnN,
  // device status feeding the reply word
  input  wire logic                 faultIn,
  input  wire logic                 intFlagIn,
  // low-power context from the rest of the device
  input  wire logic                 lowPower,
  input  wire logic [SP_CH-1:0]     spIsBattery,
  input  wire logic [SG_CH-1:0]     wakeEnSg,
  input  wire logic [SP_CH-1:0]     wakeEnSp,
  // comparator levels from the ground inputs
  input  wire logic [SG_CH-1:0]     sgCompLevel,
  // controls and events out
  output lid_chan_ctl_t             chanCtl,
  output logic                      pollTimerRun,
  output logic                      wakeEvent
);

  logic [2:0]       pinSync;
  logic             sclkS;
  logic             csNS;
  logic             mosiS;
  logic [SG_CH-1:0] sgLvl;

  // every pin and comparator level crosses two flops first;
  // select goes through inverted so the cleared sync flops read as deselected
  lid_sync #(.W(3)) uPinSync (
    .clk  (clk),
    .rstn (rstn),
    .d    ({sclk, ~csN, mosi}),
    .q    (pinSync)
  );

  lid_sync #(.W(SG_CH)) uCmpSync (
    .clk  (clk),
    .rstn (rstn),
    .d    (sgCompLevel),
    .q    (sgLvl)
  );

  assign sclkS = pinSync[2];
  assign csNS  = ~pinSync[1]; // idle high from reset, no false select edge
  assign mosiS = pinSync[0];

  // ---------------- spi slave ----------------
  lid_spi_state_t state;
  lid_spi_state_t next_state;
  logic           sclkD;
  logic           csND;
  logic [5:0]     bitCnt;
  logic [5:0]     next_bitCnt;
  logic [31:0]    rxShift;
  logic [31:0]    next_rxShift;
  logic [31:0]    txShift;
  logic [31:0]    next_txShift;
  logic [6:0]     lastAddr;
  logic [6:0]     next_lastAddr;
  logic [23:0]    regCmpOnly;
  logic [23:0]    regProgThr;
  logic [23:0]    regGndThr;
  logic [23:0]    regProgPoll;
  logic [23:0]    next_regCmpOnly;
  logic [23:0]    next_regProgThr;
  logic [23:0]    next_regGndThr;
  logic [23:0]    next_regProgPoll;
  logic           sclkRise;
  logic           sclkFall;
  logic           csFall;
  logic           csRise;
  logic           commit;
  lid_frame_t     frame;
  lid_reply_t     reply;
  logic [23:0]    rdData;

  assign sclkRise = sclkS & ~sclkD;
  assign sclkFall = ~sclkS & sclkD;
  assign csFall   = ~csNS & csND;
  assign csRise   = csNS & ~csND;
  assign frame    = lid_frame_t'(rxShift); // R10
  // a short or long frame is dropped whole, so a glitch never half-writes
  assign commit   = csRise && (state == SPI_SHIFT) && (bitCnt == FRAME_BITS);

  // read mux; unmapped addresses answer zero
  always_comb begin
    unique case (lastAddr)
      ADDR_GND_CMP_ONLY: rdData = regCmpOnly & MASK_SG; // R13
      ADDR_PROG_THR:     rdData = regProgThr & MASK_SP;
      ADDR_GND_THR:      rdData = regGndThr & MASK_SG;
      ADDR_PROG_POLL:    rdData = regProgPoll & MASK_SP;
      default:           rdData = RST_REG;
    endcase
  end

  // reply answers the address of the last full 32-bit frame
  assign reply = '{pad: REPLY_PAD, fault: faultIn, intFlag: intFlagIn,
                   regData: rdData[21:0]}; // R11

  // frame sequencing and shift registers
  always_comb begin
    next_state    = state;
    next_bitCnt   = bitCnt;
    next_rxShift  = rxShift;
    next_txShift  = txShift;
    next_lastAddr = lastAddr;
    unique case (state)
      SPI_IDLE: begin
        if (csFall) begin
          next_state   = SPI_SHIFT;
          next_bitCnt  = '0;
          next_txShift = reply;
        end
      end
      SPI_SHIFT: begin
        if (csRise) begin
          next_state = SPI_IDLE;
          if (commit) begin
            next_lastAddr = frame.addr;
          end
        end else if (sclkRise) begin
          next_rxShift = {rxShift[30:0], mosiS}; // R10
          if (bitCnt != CNT_SAT) begin
            next_bitCnt = bitCnt + 6'h01;
          end
        end else if (sclkFall) begin
          next_txShift = {txShift[30:0], 1'b0};
        end
      end
    endcase
  end

  // register writes; only the defined channel bits are kept
  always_comb begin
    next_regCmpOnly  = regCmpOnly;
    next_regProgThr  = regProgThr;
    next_regGndThr   = regGndThr;
    next_regProgPoll = regProgPoll;
    if (commit && frame.wr) begin
      unique case (frame.addr)
        ADDR_GND_CMP_ONLY: next_regCmpOnly  = frame.data & MASK_SG; // R13
        ADDR_PROG_THR:     next_regProgThr  = frame.data & MASK_SP; // R13
        ADDR_GND_THR:      next_regGndThr   = frame.data & MASK_SG; // R13
        ADDR_PROG_POLL:    next_regProgPoll = frame.data & MASK_SP; // R13
        default:           next_regCmpOnly  = regCmpOnly;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state       <= SPI_IDLE;
      sclkD       <= 1'b0;
      csND        <= 1'b1;
      bitCnt      <= '0;
      rxShift     <= '0;
      txShift     <= '0;
      lastAddr    <= RST_ADDR;
      regCmpOnly  <= RST_REG;
      regProgThr  <= RST_REG;
      regGndThr   <= RST_REG;
      regProgPoll <= RST_REG;
    end else begin
      state       <= next_state;
      sclkD       <= sclkS;
      csND        <= csNS;
      bitCnt      <= next_bitCnt;
      rxShift     <= next_rxShift;
      txShift     <= next_txShift;
      lastAddr    <= next_lastAddr;
      regCmpOnly  <= next_regCmpOnly;
      regProgThr  <= next_regProgThr;
      regGndThr   <= next_regGndThr;
      regProgPoll <= next_regProgPoll;
    end
  end

  assign miso    = txShift[31];
  assign misoEnN = (state == SPI_IDLE); // released between frames

  // ---------------- low-power sampling ----------------
  logic [7:0]       lpmCnt;
  logic [7:0]       next_lpmCnt;
  logic             lpmTick;
  logic [SG_CH-1:0] sgLast;
  logic [SG_CH-1:0] next_sgLast;
  logic             next_wakeEvent;
  logic             next_pollTimerRun;
  lid_chan_ctl_t    next_chanCtl;

  assign lpmTick = (lpmCnt == LPM_TICK_LAST);

  // divider and change detection; resolution is one tick by design
  always_comb begin
    next_lpmCnt       = lpmTick ? 8'h00 : lpmCnt + 8'h01;
    next_sgLast       = lpmTick ? sgLvl : sgLast; // R2
    next_wakeEvent    = lpmTick && lowPower &&
                        (|(regCmpOnly[SG_CH-1:0] & (sgLvl ^ sgLast))); // R1 R2
    next_pollTimerRun = lowPower && ((|wakeEnSg) || (|wakeEnSp)); // R12
  end

  // per-channel controls for the front end
  always_comb begin
    next_chanCtl = '0;
    for (int i = 0; i < SG_CH; i++) begin
      next_chanCtl.sgCompEn[i] = regCmpOnly[i]; // R1
      next_chanCtl.sgPoll[i]   = regCmpOnly[i] ? POLL_OFF : POLL_GND_1MA0; // R1
      next_chanCtl.sgThr[i]    = regGndThr[i] ? THR_NORMAL : THR_DELTA; // R6
    end
    for (int i = 0; i < SP_CH; i++) begin
      if (spIsBattery[i]) begin
        next_chanCtl.spThr[i] = THR_FIXED_4V0; // R5
      end else begin
        next_chanCtl.spThr[i] = regProgThr[i] ? THR_NORMAL : THR_DELTA; // R4
      end
      if (regProgPoll[i]) begin
        next_chanCtl.spPoll[i] = POLL_WETTING; // R9
      end else begin
        next_chanCtl.spPoll[i] = spIsBattery[i] ? POLL_BATT_2MA2 : POLL_GND_1MA0; // R8
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lpmCnt       <= '0;
      sgLast       <= '0;
      wakeEvent    <= 1'b0;
      pollTimerRun <= 1'b0;
      chanCtl      <= '0;
    end else begin
      lpmCnt       <= next_lpmCnt;
      sgLast       <= next_sgLast;
      wakeEvent    <= next_wakeEvent;
      pollTimerRun <= next_pollTimerRun;
      chanCtl      <= next_chanCtl;
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_cmpOnly;
    regCmpOnly[0] |=> chanCtl.sgCompEn[0] && chanCtl.sgPoll[0] == POLL_OFF;
  endproperty
  a_cmpOnly: assert property (p_cmpOnly) // R1
    else $error("comparator-only channel not set to comparator without current");

  property p_wake;
    lpmTick && lowPower && regCmpOnly[3] && (sgLvl[3] != sgLast[3]) |=> wakeEvent;
  endproperty
  a_wake: assert property (p_wake) // R2
    else $error("change on comparator-only channel did not wake");

  property p_noWakeOffTick;
    !lpmTick |=> !wakeEvent;
  endproperty
  a_noWakeOffTick: assert property (p_noWakeOffTick) // R2
    else $error("wake event outside a sampling tick");

  property p_progThr;
    !spIsBattery[2] |=> chanCtl.spThr[2] == ($past(regProgThr[2]) ? THR_NORMAL : THR_DELTA);
  endproperty
  a_progThr: assert property (p_progThr) // R4
    else $error("programmable ground channel threshold wrong");

  property p_battThr;
    spIsBattery[5] |=> chanCtl.spThr[5] == THR_FIXED_4V0;
  endproperty
  a_battThr: assert property (p_battThr) // R5
    else $error("battery channel not on fixed threshold");

  property p_gndThr;
    ##1 chanCtl.sgThr[13] == ($past(regGndThr[13]) ? THR_NORMAL : THR_DELTA);
  endproperty
  a_gndThr: assert property (p_gndThr) // R6
    else $error("ground channel threshold wrong");

  property p_poll;
    !regProgPoll[6] && spIsBattery[6] |=> chanCtl.spPoll[6] == POLL_BATT_2MA2;
  endproperty
  a_poll: assert property (p_poll) // R8
    else $error("battery channel default polling current wrong");

  property p_pollWet;
    regProgPoll[1] |=> chanCtl.spPoll[1] == POLL_WETTING;
  endproperty
  a_pollWet: assert property (p_pollWet) // R9
    else $error("wetting current not selected");

  property p_write;
    commit && frame.wr && frame.addr == ADDR_GND_THR
      |=> regGndThr == ($past(frame.data) & MASK_SG);
  endproperty
  a_write: assert property (p_write) // R10
    else $error("ground threshold write not stored");

  property p_reply;
    state == SPI_IDLE && csFall
      |=> txShift[31:24] == REPLY_PAD && txShift[23] == $past(faultIn)
          && txShift[22] == $past(intFlagIn);
  endproperty
  a_reply: assert property (p_reply) // R11
    else $error("reply word header wrong");

  property p_timer;
    ##1 pollTimerRun == $past(lowPower && ((|wakeEnSg) || (|wakeEnSp)));
  endproperty
  a_timer: assert property (p_timer) // R12
    else $error("polling timer run state wrong");

  property p_unused;
    regCmpOnly[23:14] == 10'h000 && regProgPoll[23:8] == 16'h0000;
  endproperty
  a_unused: assert property (p_unused) // R13
    else $error("unused register bits not zero");

endmodule : lid_top

// ==== lid_host.sv ====
`timescale 1ns/100ps
module lid_host (
  // clock
  input  wire logic clk,
  // spi pins
  input  wire logic miso,
  input  wire logic misoEnN,
  output logic      sclk,
  output logic      csN,
  output logic      mosi
);
  // idle: deselected, clock parked low
  initial begin
    sclk = 1'b0;
    csN  = 1'b1;
    mosi = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask : wait_clk

  // n bits msb first, 320 ns per bit; reply read late in the high phase
  task automatic frame(input logic [31:0] tx, input int n, output logic [31:0] rx);
    int i;
    rx = 32'h00000000;
    @(posedge clk);
    csN  <= 1'b0;
    mosi <= tx[31];
    wait_clk(8);
    for (i = 0; i < n; i++) begin
      sclk <= 1'b1;
      wait_clk(4);
      // an undriven miso must never pass as data
      rx[31-i] = (misoEnN === 1'b0) ? miso : 1'bx;
      sclk <= 1'b0;
      mosi <= (i < 31) ? tx[30-i] : ~tx[0];
      wait_clk(4);
    end
    csN  <= 1'b1;
    mosi <= ~tx[32-n];                                      // released line shows no stale bit
    wait_clk(8);
  endtask : frame
endmodule : lid_host

// ==== lid_tb.sv ====
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
module tb
  import lid_pkg::*;
;
  logic             clk;
  logic             rstn;
  logic             sclk;
  logic             csN;
  logic             mosi;
  logic             miso;
  logic             misoEnN;
  logic             faultIn;
  logic             intFlagIn;
  logic             lowPower;
  logic [SP_CH-1:0] spIsBattery;
  logic [SG_CH-1:0] wakeEnSg;
  logic [SP_CH-1:0] wakeEnSp;
  logic [SG_CH-1:0] sgCompLevel;
  lid_chan_ctl_t    chanCtl;
  logic             pollTimerRun;
  logic             wakeEvent;
  logic [23:0]      expReg [4];
  logic [6:0]       lastAddr;
  int               n_fail;
  int               n_compared;

  lid_top dut_u (
    .clk(clk), .rstn(rstn), .sclk(sclk), .csN(csN), .mosi(mosi), .miso(miso),
    .misoEnN(misoEnN), .faultIn(faultIn), .intFlagIn(intFlagIn), .lowPower(lowPower),
    .spIsBattery(spIsBattery), .wakeEnSg(wakeEnSg), .wakeEnSp(wakeEnSp),
    .sgCompLevel(sgCompLevel), .chanCtl(chanCtl), .pollTimerRun(pollTimerRun),
    .wakeEvent(wakeEvent)
  );
  lid_host host_u (
    .clk(clk), .miso(miso), .misoEnN(misoEnN), .sclk(sclk), .csN(csN), .mosi(mosi)
  );

  // 25 MHz
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // expected controls from the register image
  function automatic lid_chan_ctl_t exp_ctl();
    lid_chan_ctl_t c;
    for (int i = 0; i < SG_CH; i++) begin
      c.sgCompEn[i] = expReg[0][i];
      c.sgPoll[i]   = expReg[0][i] ? POLL_OFF : POLL_GND_1MA0;
      c.sgThr[i]    = expReg[2][i] ? THR_NORMAL : THR_DELTA;
    end
    for (int i = 0; i < SP_CH; i++) begin
      c.spThr[i]  = spIsBattery[i] ? THR_FIXED_4V0 : (expReg[1][i] ? THR_NORMAL : THR_DELTA);
      c.spPoll[i] = expReg[3][i] ? POLL_WETTING
                  : (spIsBattery[i] ? POLL_BATT_2MA2 : POLL_GND_1MA0);
    end
    return c;
  endfunction : exp_ctl

  function automatic logic [21:0] reg_val(input logic [6:0] a);
    if (a >= ADDR_GND_CMP_ONLY && a <= ADDR_PROG_POLL)
      return expReg[2'(a - ADDR_GND_CMP_ONLY)][21:0];
    return 22'h000000;
  endfunction : reg_val

  // one frame; reply holds the register of the last full 32-bit frame
  task automatic spi(input logic [6:0] a, input logic w, input logic [23:0] d, input int n);
    logic [31:0] rx;
    logic [31:0] exp;
    @(posedge clk);
    exp = {REPLY_PAD, faultIn, intFlagIn, reg_val(lastAddr)};
    exp = exp & ~(32'hFFFFFFFF >> n);
    host_u.frame({a, w, d}, n, rx);
    `CHK("reply", exp, rx)
    if (n == 32) begin
      if (w && a >= ADDR_GND_CMP_ONLY && a <= ADDR_PROG_POLL)
        expReg[2'(a - ADDR_GND_CMP_ONLY)] = d & (a[0] ? MASK_SG : MASK_SP);
      lastAddr = a;
    end
    `CHK("chanCtl", exp_ctl(), chanCtl)
  endtask : spi

  // reset values, then all bits set and a mixed pattern, with an unmapped address
  task automatic t_regs();
    logic [6:0] a;
    for (a = ADDR_GND_CMP_ONLY; a <= 7'h17; a++)
      spi(a, 1'b0, 24'h000000, 32);
    for (int p = 0; p < 2; p++) begin
      @(posedge clk);
      spIsBattery <= p ? 8'hF0 : 8'h0F;
      for (a = ADDR_GND_CMP_ONLY; a <= 7'h17; a++) begin
        @(posedge clk);
        faultIn   <= a[0];
        intFlagIn <= a[1] ^ p[0];
        // all ones pairs normal threshold with wetting current
        spi(a, 1'b1, p ? 24'h2A55A5 : 24'hFFFFFF, 32);
        spi(a, 1'b0, 24'h000000, 32);
      end
    end
  endtask : t_regs

  // a cut-short write changes neither register nor reply source
  task automatic t_short();
    spi(ADDR_PROG_THR, 1'b0, 24'h000000, 32);
    spi(ADDR_GND_THR, 1'b1, 24'h001234, 16);
    spi(ADDR_GND_THR, 1'b0, 24'h000000, 32);
    spi(ADDR_GND_THR, 1'b0, 24'h000000, 32);
  endtask : t_short

  // flip one comparator level, count wake cycles; levels are driven logic
  task automatic toggle(input int ch, output int k);
    @(posedge clk);
    sgCompLevel[ch] <= ~sgCompLevel[ch];
    k = 0;
    repeat (60) begin
      @(negedge clk);
      k += (wakeEvent === 1'b1);
    end
  endtask : toggle

  task automatic t_wake();
    int k;
    spi(ADDR_GND_CMP_ONLY, 1'b1, 24'h000008, 32);
    @(posedge clk);
    lowPower <= 1'b1;
    toggle(3, k);
    `CHK("wake ch3", 1, k)
    toggle(4, k);
    `CHK("wake ch4", 0, k)
    @(posedge clk);
    lowPower <= 1'b0;
    toggle(3, k);
    `CHK("wake awake", 0, k)
  endtask : t_wake

  task automatic timer_case(input logic lp, input logic [SG_CH-1:0] sg,
                            input logic [SP_CH-1:0] sp, input logic e);
    @(posedge clk);
    lowPower <= lp;
    wakeEnSg <= sg;
    wakeEnSp <= sp;
    repeat (3) @(negedge clk);
    `CHK("pollTimerRun", e, pollTimerRun)
  endtask : timer_case

  task automatic complete_run();
    if (n_fail == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run

  // main sequence
  initial begin
    rstn        = 1'b0;
    faultIn     = 1'b0;
    intFlagIn   = 1'b0;
    lowPower    = 1'b0;
    spIsBattery = 8'h0F;
    wakeEnSg    = 14'h0000;
    wakeEnSp    = 8'h00;
    sgCompLevel = 14'h0000;
    expReg      = '{default: RST_REG};
    lastAddr    = RST_ADDR;
    n_fail      = 0;
    n_compared  = 0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    repeat (8) @(posedge clk);
    t_regs();
    t_short();
    t_wake();
    timer_case(1'b1, 14'h0000, 8'h00, 1'b0);
    timer_case(1'b1, 14'h0000, 8'h80, 1'b1);
    timer_case(1'b1, 14'h2000, 8'h00, 1'b1);
    timer_case(1'b0, 14'h3FFF, 8'hFF, 1'b0);
    complete_run();
  end

  // watchdog, about two and a half times the expected run
  initial begin
    #(20000 * 40);
    n_fail++;
    complete_run();
  end
endmodule : tb
